// ### core/spr_defines.vh
// Summary of operation
// - Control bit 10 selects linear (0) or row-major tiled (1) surfaces.
// - Destination key on: output sprite where primary matches key, else primary.
// - 4:2:2 unpack takes Y1, U, Y2, V per the selected byte order.
// - 4:4:4 unpack ignores top byte; Y, U, V from bytes 2, 1, 0.
// - Linear first-pixel address is surface base plus linear offset.
// - Tiled surfaces use tiled offset; linear surfaces use linear offset.
// - Panning offsets count source pixels, applied before scaling.
// - Stride bits 14:6 give byte increment between sprite lines.
// - Surface write arms control, stride, position, size for vblank or disable.
// - Offsets and surface base load at vblank or while pipe disabled.
// - Position holds Y lines in 27:16, X pixels in 11:0.
// - Size holds height minus one in 27:16, width minus one in 11:0.
// - Surface base bits 31:12 are an aperture offset, 4KB aligned.
// - Tiled offset holds vertical line offset in bits 27:16.
// - Tiled offset holds horizontal pixel offset in bits 11:0.
`ifndef SPR_DEFINES_VH
`define SPR_DEFINES_VH
// ==========================================================
// Register offsets
`define SPR_OFF_CTL 20'h70280
`define SPR_OFF_LINOFF 20'h70284
`define SPR_OFF_STRIDE 20'h70288
`define SPR_OFF_POS 20'h7028C
`define SPR_OFF_SIZE 20'h70290
`define SPR_OFF_SURF 20'h7029C
`define SPR_OFF_TILEOFF 20'h702A4
// ==========================================================
// Writable masks
`define SPR_MASK_CTL 32'hDF5FE404
`define SPR_MASK_STRIDE 32'h00007FC0
`define SPR_MASK_XY 32'h0FFF0FFF
`define SPR_MASK_SURF 32'hFFFFF000
`define SPR_RESET 32'h00000000
// ==========================================================
// Field positions
`define SPRITE_CONTROL_WORD_TILED 10
`define SPRITE_CONTROL_WORD_DKEY 2
`define SPRITE_CONTROL_WORD_ORDER_HI 17
`define SPRITE_CONTROL_WORD_ORDER_LO 16
`define SPRITE_CONTROL_WORD_FMT_HI 27
`define SPRITE_CONTROL_WORD_FMT_LO 25
`define SPR_FMT_YUV422 3'h0
`define SPR_FMT_YUV444 3'h4
`define SPR_ORD_YUYV 2'h0
`define SPR_ORD_UYVY 2'h1
`define SPR_ORD_YVYU 2'h2
`define SPR_ORD_VYUY 2'h3
`define SPR_Y_HI 27
`define SPR_Y_LO 16
`define SPR_X_HI 11
`define SPR_X_LO 0
`define SPR_STR_HI 14
`define SPR_STR_LO 6
`endif

// ### core/spr_surface_regs.v
`include "spr_defines.vh"
`default_nettype none
module spr_surface_regs #(
    parameter AW = 20
) (
    input wire clk,
    input wire rst,
    input wire [AW-1:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_wdata,
    output reg [31:0] reg_rdata,
    input wire vblank_start,
    input wire pipe_enabled,
    input wire [31:0] pix_word,
    input wire [23:0] primary_pix,
    input wire [23:0] sprite_pix,
    input wire primary_key_match,
    output reg [31:0] first_pix_addr,
    output reg tiled_mode,
    output reg [11:0] tile_x,
    output reg [11:0] tile_y,
    output reg [8:0] line_stride,
    output reg [11:0] pos_x,
    output reg [11:0] pos_y,
    output reg [11:0] width_m1,
    output reg [11:0] height_m1,
    output reg [7:0] pix_y1,
    output reg [7:0] pix_u,
    output reg [7:0] pix_y2,
    output reg [7:0] pix_v,
    output reg [23:0] blend_pix,
    output reg armed
);
// ==========================================================
// Software-visible staging copies
reg [31:0] ctl_reg, linoff_reg, stride_reg, pos_reg, size_reg;
reg [31:0] surf_reg, tileoff_reg;
// ==========================================================
// Active copies used by the plane
reg [31:0] act_ctl_reg, act_linoff_reg, act_stride_reg, act_pos_reg;
reg [31:0] act_size_reg, act_surf_reg, act_tileoff_reg;
reg armed_reg;
wire sprite_on = act_ctl_reg[31];
// Disabled pipe or sprite means no frame to tear, so load at once
wire arm_load = armed_reg & (vblank_start | ~pipe_enabled | ~sprite_on);
wire free_load = vblank_start | ~pipe_enabled;
wire wr_surf = reg_wr && reg_addr == `SPR_OFF_SURF;
// ==========================================================
function [7:0] pick_byte;
    input [31:0] w;
    input [1:0] idx;
    begin
        pick_byte = w[idx*8 +: 8];
    end
endfunction
// ==========================================================
// Register writes
always @(posedge clk or posedge rst) begin
    if (rst) begin
        ctl_reg <= `SPR_RESET;
        linoff_reg <= `SPR_RESET;
        stride_reg <= `SPR_RESET;
        pos_reg <= `SPR_RESET;
        size_reg <= `SPR_RESET;
        surf_reg <= `SPR_RESET;
        tileoff_reg <= `SPR_RESET;
    end else if (reg_wr) begin
        case (reg_addr)
            `SPR_OFF_CTL: ctl_reg <= reg_wdata & `SPR_MASK_CTL;
            `SPR_OFF_LINOFF: linoff_reg <= reg_wdata;
            `SPR_OFF_STRIDE: stride_reg <= reg_wdata & `SPR_MASK_STRIDE;
            `SPR_OFF_POS: pos_reg <= reg_wdata & `SPR_MASK_XY;
            `SPR_OFF_SIZE: size_reg <= reg_wdata & `SPR_MASK_XY;
            `SPR_OFF_SURF: surf_reg <= reg_wdata & `SPR_MASK_SURF;
            `SPR_OFF_TILEOFF: tileoff_reg <= reg_wdata & `SPR_MASK_XY;
            default: ;
        endcase
    end
end
// ==========================================================
// Double buffering
always @(posedge clk or posedge rst) begin
    if (rst) begin
        armed_reg <= 1'b0;
        act_ctl_reg <= `SPR_RESET;
        act_stride_reg <= `SPR_RESET;
        act_pos_reg <= `SPR_RESET;
        act_size_reg <= `SPR_RESET;
        act_linoff_reg <= `SPR_RESET;
        act_surf_reg <= `SPR_RESET;
        act_tileoff_reg <= `SPR_RESET;
    end else begin
        // A fresh surface write re-arms even in the load cycle
        armed_reg <= wr_surf | (armed_reg & ~arm_load);
        if (arm_load) begin
            act_ctl_reg <= ctl_reg;
            act_stride_reg <= stride_reg;
            act_pos_reg <= pos_reg;
            act_size_reg <= size_reg;
        end
        if (free_load) begin
            act_linoff_reg <= linoff_reg;
            act_surf_reg <= surf_reg;
            act_tileoff_reg <= tileoff_reg;
        end
    end
end
// ==========================================================
// Read back staging values; unmapped reads give zero
always @(posedge clk or posedge rst) begin
    if (rst) begin
        reg_rdata <= `SPR_RESET;
    end else if (reg_rd) begin
        case (reg_addr)
            `SPR_OFF_CTL: reg_rdata <= ctl_reg;
            `SPR_OFF_LINOFF: reg_rdata <= linoff_reg;
            `SPR_OFF_STRIDE: reg_rdata <= stride_reg;
            `SPR_OFF_POS: reg_rdata <= pos_reg;
            `SPR_OFF_SIZE: reg_rdata <= size_reg;
            `SPR_OFF_SURF: reg_rdata <= surf_reg;
            `SPR_OFF_TILEOFF: reg_rdata <= tileoff_reg;
            default: reg_rdata <= `SPR_RESET;
        endcase
    end
end
// ==========================================================
// Plane outputs from active copies
reg [7:0] y1_next, u_next, y2_next, v_next;
always @* begin
    y1_next = pick_byte(pix_word, 2'h0);
    u_next = pick_byte(pix_word, 2'h1);
    y2_next = pick_byte(pix_word, 2'h2);
    v_next = pick_byte(pix_word, 2'h3);
    case (act_ctl_reg[`SPRITE_CONTROL_WORD_FMT_HI:`SPRITE_CONTROL_WORD_FMT_LO])
        `SPR_FMT_YUV444: begin
            y1_next = pick_byte(pix_word, 2'h2);
            u_next = pick_byte(pix_word, 2'h1);
            y2_next = pick_byte(pix_word, 2'h2);
            v_next = pick_byte(pix_word, 2'h0);
        end
        `SPR_FMT_YUV422: begin
            case (act_ctl_reg[`SPRITE_CONTROL_WORD_ORDER_HI:`SPRITE_CONTROL_WORD_ORDER_LO])
                `SPR_ORD_UYVY: begin
                    y1_next = pick_byte(pix_word, 2'h1);
                    u_next = pick_byte(pix_word, 2'h0);
                    y2_next = pick_byte(pix_word, 2'h3);
                    v_next = pick_byte(pix_word, 2'h2);
                end
                `SPR_ORD_YVYU: begin
                    u_next = pick_byte(pix_word, 2'h3);
                    v_next = pick_byte(pix_word, 2'h1);
                end
                `SPR_ORD_VYUY: begin
                    y1_next = pick_byte(pix_word, 2'h1);
                    u_next = pick_byte(pix_word, 2'h2);
                    y2_next = pick_byte(pix_word, 2'h3);
                    v_next = pick_byte(pix_word, 2'h0);
                end
                default: ;
            endcase
        end
        default: ;
    endcase
end
always @(posedge clk or posedge rst) begin
    if (rst) begin
        first_pix_addr <= `SPR_RESET;
        tiled_mode <= 1'b0;
        tile_x <= 12'h000;
        tile_y <= 12'h000;
        line_stride <= 9'h000;
        pos_x <= 12'h000;
        pos_y <= 12'h000;
        width_m1 <= 12'h000;
        height_m1 <= 12'h000;
        pix_y1 <= 8'h00;
        pix_u <= 8'h00;
        pix_y2 <= 8'h00;
        pix_v <= 8'h00;
        blend_pix <= 24'h000000;
        armed <= 1'b0;
    end else begin
        tiled_mode <= act_ctl_reg[`SPRITE_CONTROL_WORD_TILED];
        // Offsets are in source pixels; scaler sits downstream
        if (act_ctl_reg[`SPRITE_CONTROL_WORD_TILED]) begin
            first_pix_addr <= act_surf_reg;
            tile_x <= act_tileoff_reg[`SPR_X_HI:`SPR_X_LO];
            tile_y <= act_tileoff_reg[`SPR_Y_HI:`SPR_Y_LO];
        end else begin
            first_pix_addr <= act_surf_reg + act_linoff_reg;
            tile_x <= 12'h000;
            tile_y <= 12'h000;
        end
        line_stride <= act_stride_reg[`SPR_STR_HI:`SPR_STR_LO];
        pos_x <= act_pos_reg[`SPR_X_HI:`SPR_X_LO];
        pos_y <= act_pos_reg[`SPR_Y_HI:`SPR_Y_LO];
        width_m1 <= act_size_reg[`SPR_X_HI:`SPR_X_LO];
        height_m1 <= act_size_reg[`SPR_Y_HI:`SPR_Y_LO];
        pix_y1 <= y1_next;
        pix_u <= u_next;
        pix_y2 <= y2_next;
        pix_v <= v_next;
        // Relies on software never enabling both key kinds
        if (act_ctl_reg[`SPRITE_CONTROL_WORD_DKEY] && !primary_key_match)
            blend_pix <= primary_pix;
        else
            blend_pix <= sprite_pix;
        armed <= armed_reg;
    end
end
endmodule
`default_nettype wire

// ### tb/spr_surface_regs_assertions.sv
`include "spr_defines.vh"
`default_nettype none
module spr_chk #(
    parameter AW = 20
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [AW-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic vblank_start,
    input wire logic pipe_enabled,
    input wire logic [31:0] pix_word,
    input wire logic [23:0] primary_pix,
    input wire logic [23:0] sprite_pix,
    input wire logic primary_key_match,
    input wire logic [31:0] first_pix_addr,
    input wire logic tiled_mode,
    input wire logic [11:0] tile_x,
    input wire logic [11:0] tile_y,
    input wire logic [7:0] pix_y1,
    input wire logic [23:0] blend_pix,
    input wire logic armed
);
    // ==========================================
    // Shadows of written offsets
    logic [31:0] lin_sh, surf_sh, til_sh;
    wire logic surf_wr = reg_wr && reg_addr == `SPR_OFF_SURF;
    wire logic ofs_wr = reg_wr && (reg_addr == `SPR_OFF_LINOFF ||
        reg_addr == `SPR_OFF_TILEOFF || surf_wr);
    wire logic mapped = reg_addr inside {`SPR_OFF_CTL, `SPR_OFF_LINOFF,
        `SPR_OFF_STRIDE, `SPR_OFF_POS, `SPR_OFF_SIZE, `SPR_OFF_SURF,
        `SPR_OFF_TILEOFF};
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lin_sh <= '0;
            surf_sh <= '0;
            til_sh <= '0;
        end else if (reg_wr) begin
            if (reg_addr == `SPR_OFF_LINOFF) lin_sh <= reg_wdata;
            if (surf_wr) surf_sh <= reg_wdata & `SPR_MASK_SURF;
            if (reg_addr == `SPR_OFF_TILEOFF) til_sh <= reg_wdata & `SPR_MASK_XY;
        end
    end
    // ==========================================
    // Properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Four quiet cycles cover the staging, active and output stages
    sequence s_quiet;
        (!pipe_enabled && !ofs_wr)[*4];
    endsequence
    sequence s_vbl_clear;
        (vblank_start && !surf_wr) ##1 !surf_wr ##1 !surf_wr;
    endsequence
    chk_addr_sum: assert property (s_quiet |-> first_pix_addr ==
        (tiled_mode ? surf_sh : surf_sh + lin_sh)) else $error("bad address");
    chk_tile_xy: assert property (s_quiet ##0 tiled_mode |->
        tile_x == til_sh[11:0] && tile_y == til_sh[27:16]) else $error("tile");
    chk_tile_zero: assert property (!tiled_mode |-> tile_x == 12'h000 &&
        tile_y == 12'h000) else $error("tile offset used when linear");
    chk_arm_rise: assert property ($rose(armed) |-> $past(surf_wr, 2))
        else $error("armed without surface write");
    chk_arm_clear: assert property (s_vbl_clear |=> !armed)
        else $error("armed after vblank");
    chk_blend_key: assert property (1'b1 |=> blend_pix == $past(sprite_pix) ||
        (!$past(primary_key_match) && blend_pix == $past(primary_pix)))
        else $error("blend source");
    chk_unpack_y: assert property (1'b1 |=> pix_y1 == $past(pix_word[7:0]) ||
        pix_y1 == $past(pix_word[15:8]) || pix_y1 == $past(pix_word[23:16]))
        else $error("luma byte");
    chk_unmapped_rd: assert property (reg_rd && !mapped |=> reg_rdata == 32'h0)
        else $error("unmapped read");
    chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved");
endmodule
bind spr_surface_regs spr_chk #(.AW(AW)) i_spr_chk (.*);
`default_nettype wire

// ### tb/tb_top.sv
`include "spr_defines.vh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, vblank_start = 0;
    logic pipe_enabled = 0, primary_key_match = 0, tiled_mode, armed;
    logic [19:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0, pix_word = '0, reg_rdata, first_pix_addr;
    logic [23:0] primary_pix = 24'h0000AA, sprite_pix = 24'h0000BB, blend_pix;
    logic [11:0] tile_x, tile_y, pos_x, pos_y, width_m1, height_m1;
    logic [8:0] line_stride;
    logic [7:0] pix_y1, pix_u, pix_y2, pix_v;
    int n_fail = 0, checked = 0, cyc = 0;
    spr_surface_regs i_spr_surface_regs (.*);
    initial forever #5 clk = ~clk;
    // ==========================================
    // Helpers
    task automatic finish_test();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // A hang would otherwise never reach the verdict
    always @(posedge clk) if (++cyc == 5000) begin
        n_fail++;
        finish_test();
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [19:0] a, input logic [31:0] d);
        @(negedge clk);
        reg_wr = 1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 0;
    endtask
    task automatic rd(input logic [19:0] a, input logic [31:0] e);
        @(negedge clk);
        reg_rd = 1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 0;
        chk(reg_rdata, e);
    endtask
    task automatic wait4();
        repeat (4) @(negedge clk);
    endtask
    task automatic cfg(input logic [31:0] c);
        wr(`SPR_OFF_CTL, c);
        wr(`SPR_OFF_SURF, 32'h00400000);
        wait4();
    endtask
    // ==========================================
    // Scenarios
    task automatic t_regs();
        logic [19:0] a[8] = '{`SPR_OFF_CTL, `SPR_OFF_LINOFF, `SPR_OFF_STRIDE,
            `SPR_OFF_POS, `SPR_OFF_SIZE, `SPR_OFF_SURF, `SPR_OFF_TILEOFF,
            20'h70294};
        logic [31:0] m[8] = '{32'hDF1FE404, 32'hFFFFFFFF, 32'h00007FC0,
            32'h0FFF0FFF, 32'h0FFF0FFF, 32'hFFFFF000, 32'h0FFF0FFF, 32'h0};
        chk(first_pix_addr, 32'h0);
        foreach (a[i]) rd(a[i], 32'h0);
        foreach (a[i]) begin
            // Source key stays off so the two key kinds never meet
            wr(a[i], i == 0 ? 32'hFFBFFFFF : 32'hFFFFFFFF);
            rd(a[i], m[i]);
        end
        $display("regs done");
    endtask
    task automatic t_addr();
        cfg(32'h80000000);
        wr(`SPR_OFF_LINOFF, 32'h00001234);
        wr(`SPR_OFF_TILEOFF, 32'h00050007);
        wr(`SPR_OFF_STRIDE, 32'h00000E00);
        wr(`SPR_OFF_POS, 32'h00200010);
        wr(`SPR_OFF_SIZE, 32'h003F007F);
        cfg(32'h80000000);
        chk(first_pix_addr, 32'h00401234);
        chk({tiled_mode, tile_y, tile_x}, 32'h0);
        chk(line_stride, 32'h38);
        chk({pos_y, pos_x}, 32'h020010);
        chk({height_m1, width_m1}, 32'h03F07F);
        cfg(32'h80000400);
        chk(first_pix_addr, 32'h00400000);
        chk({tiled_mode, tile_y, tile_x}, 32'h1005007);
        $display("addr done");
    endtask
    task automatic t_arm();
        @(negedge clk);
        pipe_enabled = 1;
        wr(`SPR_OFF_STRIDE, 32'h00001000);
        wr(`SPR_OFF_TILEOFF, 32'h00090003);
        wait4();
        chk({armed, line_stride, tile_x}, 32'h038007);
        wr(`SPR_OFF_SURF, 32'h00800000);
        wait4();
        chk({armed, line_stride, tile_x}, 32'h238007);
        chk(first_pix_addr, 32'h00400000);
        @(negedge clk);
        vblank_start = 1;
        @(negedge clk);
        vblank_start = 0;
        wait4();
        chk({armed, line_stride, tile_x}, 32'h040003);
        chk(first_pix_addr, 32'h00800000);
        pipe_enabled = 0;
        $display("arm done");
    endtask
    task automatic t_unpack();
        logic [31:0] e[5] = '{32'h11223344, 32'h22114433, 32'h11443322,
            32'h22334411, 32'h33223311};
        pix_word = 32'h44332211;
        for (int i = 0; i < 5; i++) begin
            cfg(i < 4 ? 32'h80000000 | (i << 16) : 32'h88000000);
            chk({pix_y1, pix_u, pix_y2, pix_v}, e[i]);
        end
        $display("unpack done");
    endtask
    task automatic t_blend();
        cfg(32'h80000004);
        for (int i = 0; i < 2; i++) begin
            primary_key_match = i[0];
            repeat (2) @(negedge clk);
            chk(blend_pix, i ? 24'h0000BB : 24'h0000AA);
        end
        cfg(32'h80000000);
        chk(blend_pix, 24'h0000BB);
        $display("blend done");
    endtask
    initial begin
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst = 0;
        t_regs();
        t_addr();
        t_arm();
        t_unpack();
        t_blend();
        finish_test();
    end
endmodule
`default_nettype wire
